// ### core/ccr_cfg.svh
// register offsets, field positions, reset values and code tables for the charger bank
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH
`define CCR_ADDR_PRIMARY 8'h0A
`define CCR_ADDR_THRESH 8'h0B
`define CCR_ADDR_TIMER 8'h0C
`define CCR_RST_PRIMARY 8'h00
`define CCR_RST_THRESH 8'h00
`define CCR_RST_TIMER 8'h00
`define CCR_RST_PIN_STAGES 2'h3
`define CCR_RST_PIN_PREV 1'h1
`define CCR_THRESH_MASK 8'h7F
`define CCR_TIMER_MASK 8'h3F
`define CCR_REG_RESERVED 3'h7
`define CCR_BIT_AUTOSTOP 7
`define CCR_BIT_RESTART 6
`define CCR_BIT_CHGON 0
`define CCR_RECHG_BASE_MV 10'h046
`define CCR_RECHG_STEP_MV 10'h032
`define CCR_VREG_BASE_MV 13'h0FD2
`define CCR_VREG_STEP_MV 13'h0032
`define CCR_VPRE_BASE_MV 13'h0834
`define CCR_VPRE_STEP_MV 13'h0096
`endif

// ### core/ccr_pkg.sv
// types shared by the charger configuration bank
package ccr_pkg;
  typedef struct packed {
    logic auto_stop_enable;
    logic auto_restart_enable;
    logic [1:0] recharge_offset_select;
    logic [2:0] regulation_voltage_select;
    logic charger_on;
  } ccr_primary_t;
  typedef struct packed {
    logic unused7;
    logic [2:0] precharge_voltage_select;
    logic [1:0] precharge_current_select;
    logic [1:0] done_current_select;
  } ccr_thresh_t;
  typedef struct packed {
    logic [1:0] unused76;
    logic [1:0] maintain_timer_select;
    logic [1:0] fast_timer_select;
    logic [1:0] pre_timer_select;
  } ccr_timer_t;
  // decoded settings handed to the charger core
  typedef struct packed {
    logic auto_stop_enable;
    logic auto_restart_enable;
    logic charger_on;
    logic regulation_valid;
    logic [12:0] regulation_mv;
    logic [9:0] recharge_drop_mv;
    logic [12:0] precharge_mv;
    logic [4:0] precharge_current_pct;
    logic [4:0] done_current_pct;
    logic [9:0] maintain_min;
    logic [9:0] fast_limit_min;
    logic [7:0] pre_limit_min;
  } ccr_settings_t;
  typedef struct packed {
    ccr_primary_t primary;
    ccr_thresh_t thresh;
    ccr_timer_t timer;
    logic [1:0] supply_sync;
    logic supply_prev;
    logic [7:0] rdata;
  } ccr_state_t;
endpackage

// ### core/ccr_decode.sv
// decodes stored register fields into charger settings
`include "ccr_cfg.svh"
module ccr_decode
  import ccr_pkg::*;
(
  input ccr_primary_t primary,
  input ccr_thresh_t thresh,
  input ccr_timer_t timer,
  output ccr_settings_t settings
);
  // fraction of fast-charge current in percent, 5/10/20/30
  function automatic logic [4:0] frac_pct(input logic [1:0] code);
    unique case (code)
      2'h0: frac_pct = 5'h05;
      2'h1: frac_pct = 5'h0A;
      2'h2: frac_pct = 5'h14;
      2'h3: frac_pct = 5'h1E;
    endcase
  endfunction

  always_comb begin
    settings.auto_stop_enable = primary.auto_stop_enable;
    settings.auto_restart_enable = primary.auto_restart_enable;
    settings.charger_on = primary.charger_on;
    // reserved code flagged so the core never regulates above 4.35V
    settings.regulation_valid = primary.regulation_voltage_select != `CCR_REG_RESERVED;
    settings.regulation_mv = `CCR_VREG_BASE_MV
      + `CCR_VREG_STEP_MV * {10'h000, primary.regulation_voltage_select};
    settings.recharge_drop_mv = `CCR_RECHG_BASE_MV
      + `CCR_RECHG_STEP_MV * {8'h00, primary.recharge_offset_select};
    settings.precharge_mv = `CCR_VPRE_BASE_MV
      + `CCR_VPRE_STEP_MV * {10'h000, thresh.precharge_voltage_select};
    settings.precharge_current_pct = frac_pct(thresh.precharge_current_select);
    settings.done_current_pct = frac_pct(thresh.done_current_select);
    unique case (timer.maintain_timer_select)
      2'h0: settings.maintain_min = 10'h000;
      2'h1: settings.maintain_min = 10'h00F;
      2'h2: settings.maintain_min = 10'h01E;
      2'h3: settings.maintain_min = 10'h03C;
    endcase
    unique case (timer.fast_timer_select)
      2'h0: settings.fast_limit_min = 10'h04B;
      2'h1: settings.fast_limit_min = 10'h096;
      2'h2: settings.fast_limit_min = 10'h12C;
      2'h3: settings.fast_limit_min = 10'h258;
    endcase
    unique case (timer.pre_timer_select)
      2'h0: settings.pre_limit_min = 8'h1E;
      2'h1: settings.pre_limit_min = 8'h3C;
      2'h2: settings.pre_limit_min = 8'h78;
      2'h3: settings.pre_limit_min = 8'hF0;
    endcase
  end
endmodule

// ### core/ccr_bank.sv
// charger configuration register bank with supply-edge reload
// What this block does
// - bit 7 of primary register enables auto-stop from maintain to maintain-done
// - bit 6 enables automatic restart when battery falls below restart threshold
// - two-bit field sets restart threshold 70, 120, 170 or 220 mV below regulation
// - three-bit field sets regulation 4.05V to 4.35V in 50mV steps, 111 reserved
// - bit 0 turns charging on or off, system supply unaffected
// - all three registers return to defaults on charger supply rising edge
// - pre-charge voltage 2.10V to 3.15V in 0.15V steps
// - pre-charge current 0.05, 0.1, 0.2 or 0.3 of fast-charge current
// - done threshold 0.05, 0.1, 0.2 or 0.3 of fast-charge current
// - maintain timer 0, 15, 30 or 60 minutes, bits 5:4
// - fast-charge limit 75, 150, 300 or 600 minutes, bits 3:2
// - pre-charge limit 30, 60, 120 or 240 minutes, bits 1:0
`include "ccr_cfg.svh"
module ccr_bank
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic write_protect,
  input wire logic charger_input_supply,
  output ccr_settings_t settings
);
  ccr_state_t s_q;
  ccr_state_t s_d;
  logic supply_rise;

  // power-on contents; pin stages start high so a supply already present
  // when reset lifts is not taken for a fresh plug-in edge
  localparam ccr_state_t state_rst = '{
    primary: ccr_primary_t'(`CCR_RST_PRIMARY),
    thresh: ccr_thresh_t'(`CCR_RST_THRESH),
    timer: ccr_timer_t'(`CCR_RST_TIMER),
    supply_sync: `CCR_RST_PIN_STAGES,
    supply_prev: `CCR_RST_PIN_PREV,
    rdata: '0
  };

  // address match driving reg_hit only; read and write paths decode reg_addr in their own case statements
  function automatic logic is_bank(input logic [7:0] a);
    is_bank = (a == `CCR_ADDR_PRIMARY) || (a == `CCR_ADDR_THRESH) || (a == `CCR_ADDR_TIMER);
  endfunction

  assign supply_rise = s_q.supply_sync[1] & ~s_q.supply_prev;
  assign reg_hit = is_bank(reg_addr);

  // next state; supply edge reload beats a simultaneous write
  always_comb begin
    s_d = s_q;
    s_d.supply_sync = {s_q.supply_sync[0], charger_input_supply};
    s_d.supply_prev = s_q.supply_sync[1];
    if (supply_rise) begin
      s_d.primary = ccr_primary_t'(`CCR_RST_PRIMARY);
      s_d.thresh = ccr_thresh_t'(`CCR_RST_THRESH);
      s_d.timer = ccr_timer_t'(`CCR_RST_TIMER);
    end else if (reg_wr) begin
      unique case (reg_addr)
        `CCR_ADDR_PRIMARY: begin
          if (!write_protect) begin
            s_d.primary = ccr_primary_t'(reg_wdata);
          end
        end
        `CCR_ADDR_THRESH: s_d.thresh = ccr_thresh_t'(reg_wdata & `CCR_THRESH_MASK);
        `CCR_ADDR_TIMER: s_d.timer = ccr_timer_t'(reg_wdata & `CCR_TIMER_MASK);
        default: ;
      endcase
    end
    // read data registered; unmapped addresses read zero
    if (reg_rd) begin
      unique case (reg_addr)
        `CCR_ADDR_PRIMARY: s_d.rdata = s_q.primary;
        `CCR_ADDR_THRESH: s_d.rdata = s_q.thresh;
        `CCR_ADDR_TIMER: s_d.rdata = s_q.timer;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // single state register; reset puts every field at its default
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= state_rst;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;

  ccr_decode u_decode (
    .primary(s_q.primary),
    .thresh(s_q.thresh),
    .timer(s_q.timer),
    .settings(settings)
  );

  // primary register write path and its protection
  a_protect_holds: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCR_ADDR_PRIMARY && write_protect && !supply_rise
    |=> $stable(s_q.primary)) else $error("primary changed under write protect");
  a_primary_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCR_ADDR_PRIMARY && !write_protect && !supply_rise
    |=> s_q.primary == $past(reg_wdata)) else $error("primary write lost");
  a_stop_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCR_ADDR_PRIMARY && !write_protect && !supply_rise
    |=> settings.auto_stop_enable == $past(reg_wdata[`CCR_BIT_AUTOSTOP]))
    else $error("auto-stop bit misplaced");
  a_restart_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCR_ADDR_PRIMARY && !write_protect && !supply_rise
    |=> settings.auto_restart_enable == $past(reg_wdata[`CCR_BIT_RESTART]))
    else $error("auto-restart bit misplaced");
  a_enable_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCR_ADDR_PRIMARY && !write_protect && !supply_rise
    |=> settings.charger_on == $past(reg_wdata[`CCR_BIT_CHGON]))
    else $error("charger enable bit misplaced");
  a_chg_follow: assert property (@(posedge clk) disable iff (!rst_b)
    settings.charger_on == s_q.primary[`CCR_BIT_CHGON]
    && settings.auto_stop_enable == s_q.primary[`CCR_BIT_AUTOSTOP]
    && settings.auto_restart_enable == s_q.primary[`CCR_BIT_RESTART])
    else $error("control bits misrouted");

  // supply edge reload; a write in the same cycle must lose
  a_supply_reload: assert property (@(posedge clk) disable iff (!rst_b)
    supply_rise |=> s_q.primary == ccr_primary_t'(`CCR_RST_PRIMARY)
      && s_q.timer == ccr_timer_t'(`CCR_RST_TIMER)
      && s_q.thresh == ccr_thresh_t'(`CCR_RST_THRESH))
    else $error("no reload on supply edge");

  // masked registers keep their unused bits clear
  a_upper_zero: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.thresh.unused7 == 1'h0 && s_q.timer.unused76 == 2'h0)
    else $error("unused bits set");
  a_thresh_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCR_ADDR_THRESH && !supply_rise
    |=> s_q.thresh == ($past(reg_wdata) & `CCR_THRESH_MASK))
    else $error("threshold write lost");
  a_timer_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCR_ADDR_TIMER && !supply_rise
    |=> s_q.timer == ($past(reg_wdata) & `CCR_TIMER_MASK))
    else $error("timer write lost");
  a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && !reg_hit && !supply_rise
    |=> $stable(s_q.primary) && $stable(s_q.thresh) && $stable(s_q.timer))
    else $error("unmapped write changed a register");

  // registered read port; data stands until the next read strobe
  a_read_primary: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == `CCR_ADDR_PRIMARY |=> reg_rdata == $past(s_q.primary))
    else $error("primary read wrong");
  a_read_thresh: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == `CCR_ADDR_THRESH |=> reg_rdata == $past(s_q.thresh))
    else $error("threshold read wrong");
  a_read_timer: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == `CCR_ADDR_TIMER |=> reg_rdata == $past(s_q.timer))
    else $error("timer read wrong");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // decoded values against the code tables, not against the decoder's arithmetic
  a_rechg_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.primary.recharge_offset_select == 2'h0 && settings.recharge_drop_mv == 10'h046)
    || (s_q.primary.recharge_offset_select == 2'h1 && settings.recharge_drop_mv == 10'h078)
    || (s_q.primary.recharge_offset_select == 2'h2 && settings.recharge_drop_mv == 10'h0AA)
    || (s_q.primary.recharge_offset_select == 2'h3 && settings.recharge_drop_mv == 10'h0DC))
    else $error("recharge offset decode wrong");
  a_reg_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.primary.regulation_voltage_select == 3'h0 && settings.regulation_mv == 13'h0FD2)
    || (s_q.primary.regulation_voltage_select == 3'h1 && settings.regulation_mv == 13'h1004)
    || (s_q.primary.regulation_voltage_select == 3'h2 && settings.regulation_mv == 13'h1036)
    || (s_q.primary.regulation_voltage_select == 3'h3 && settings.regulation_mv == 13'h1068)
    || (s_q.primary.regulation_voltage_select == 3'h4 && settings.regulation_mv == 13'h109A)
    || (s_q.primary.regulation_voltage_select == 3'h5 && settings.regulation_mv == 13'h10CC)
    || (s_q.primary.regulation_voltage_select == 3'h6 && settings.regulation_mv == 13'h10FE)
    || s_q.primary.regulation_voltage_select == `CCR_REG_RESERVED)
    else $error("regulation decode wrong");
  a_reg_reserved: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.primary.regulation_voltage_select == `CCR_REG_RESERVED) != settings.regulation_valid)
    else $error("reserved regulation code not flagged");
  a_reg_range: assert property (@(posedge clk) disable iff (!rst_b)
    settings.regulation_valid |-> settings.regulation_mv <= 13'h10FE
      && settings.regulation_mv >= 13'h0FD2) else $error("regulation out of range");
  a_rechg_range: assert property (@(posedge clk) disable iff (!rst_b)
    settings.recharge_drop_mv >= 10'h046 && settings.recharge_drop_mv <= 10'h0DC)
    else $error("recharge offset out of range");
  a_pre_range: assert property (@(posedge clk) disable iff (!rst_b)
    settings.precharge_mv >= 13'h0834 && settings.precharge_mv <= 13'h0C4E)
    else $error("precharge voltage out of range");
  a_pre_volt_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.thresh.precharge_voltage_select == 3'h0 && settings.precharge_mv == 13'h0834)
    || (s_q.thresh.precharge_voltage_select == 3'h1 && settings.precharge_mv == 13'h08CA)
    || (s_q.thresh.precharge_voltage_select == 3'h2 && settings.precharge_mv == 13'h0960)
    || (s_q.thresh.precharge_voltage_select == 3'h3 && settings.precharge_mv == 13'h09F6)
    || (s_q.thresh.precharge_voltage_select == 3'h4 && settings.precharge_mv == 13'h0A8C)
    || (s_q.thresh.precharge_voltage_select == 3'h5 && settings.precharge_mv == 13'h0B22)
    || (s_q.thresh.precharge_voltage_select == 3'h6 && settings.precharge_mv == 13'h0BB8)
    || (s_q.thresh.precharge_voltage_select == 3'h7 && settings.precharge_mv == 13'h0C4E))
    else $error("precharge voltage decode wrong");
  a_pre_current_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.thresh.precharge_current_select == 2'h0 && settings.precharge_current_pct == 5'h05)
    || (s_q.thresh.precharge_current_select == 2'h1 && settings.precharge_current_pct == 5'h0A)
    || (s_q.thresh.precharge_current_select == 2'h2 && settings.precharge_current_pct == 5'h14)
    || (s_q.thresh.precharge_current_select == 2'h3 && settings.precharge_current_pct == 5'h1E))
    else $error("precharge current decode wrong");
  a_done_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.thresh.done_current_select == 2'h0 && settings.done_current_pct == 5'h05)
    || (s_q.thresh.done_current_select == 2'h1 && settings.done_current_pct == 5'h0A)
    || (s_q.thresh.done_current_select == 2'h2 && settings.done_current_pct == 5'h14)
    || (s_q.thresh.done_current_select == 2'h3 && settings.done_current_pct == 5'h1E))
    else $error("done threshold decode wrong");
  a_maint_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.timer.maintain_timer_select == 2'h0 && settings.maintain_min == 10'h000)
    || (s_q.timer.maintain_timer_select == 2'h1 && settings.maintain_min == 10'h00F)
    || (s_q.timer.maintain_timer_select == 2'h2 && settings.maintain_min == 10'h01E)
    || (s_q.timer.maintain_timer_select == 2'h3 && settings.maintain_min == 10'h03C))
    else $error("maintain timer decode wrong");
  a_fast_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.timer.fast_timer_select == 2'h0 && settings.fast_limit_min == 10'h04B)
    || (s_q.timer.fast_timer_select == 2'h1 && settings.fast_limit_min == 10'h096)
    || (s_q.timer.fast_timer_select == 2'h2 && settings.fast_limit_min == 10'h12C)
    || (s_q.timer.fast_timer_select == 2'h3 && settings.fast_limit_min == 10'h258))
    else $error("fast-charge timer decode wrong");
  a_pre_timer_table: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.timer.pre_timer_select == 2'h0 && settings.pre_limit_min == 8'h1E)
    || (s_q.timer.pre_timer_select == 2'h1 && settings.pre_limit_min == 8'h3C)
    || (s_q.timer.pre_timer_select == 2'h2 && settings.pre_limit_min == 8'h78)
    || (s_q.timer.pre_timer_select == 2'h3 && settings.pre_limit_min == 8'hF0))
    else $error("pre-charge timer decode wrong");
endmodule

// ### verification/ccr_host.sv
// host-side model driving the parallel register port of the charger bank
module ccr_host
  import ccr_pkg::*;
(
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one-cycle strobe; the trailing delay lets register updates land first
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // read data is registered, so it is picked up one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// ### verification/ccr_bank_tb.sv
// self-checking bench for the charger configuration bank
module ccr_bank_tb;
  import ccr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, wp, sup, wr, rd, hit;
  logic [7:0] addr, wdata, rdata, v;
  ccr_settings_t st;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  ccr_host host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata));
  ccr_bank DUT (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rd(rd), .reg_rdata(rdata), .reg_hit(hit), .write_protect(wp),
    .charger_input_supply(sup), .settings(st));
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    check(v, e);
  endtask
  // hang guard, well above the roughly one hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    wp = 1'b0;
    sup = 1'b1;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // settle past any reload caused by the supply already being high
    repeat (10) @(posedge clk);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0C, 8'h00);
    check(hit, 1'b1);
    host.wr(8'h0C, 8'hFF);
    check(st.maintain_min, 10'h03C);
    check(st.fast_limit_min, 10'h258);
    check(st.pre_limit_min, 8'hF0);
    rdchk(8'h0C, 8'h3F);
    host.wr(8'h0C, 8'h15);
    check(st.maintain_min, 10'h00F);
    check(st.fast_limit_min, 10'h096);
    check(st.pre_limit_min, 8'h3C);
    host.wr(8'h0B, 8'hFF);
    check({st.precharge_mv, st.precharge_current_pct}, {13'h0C4E, 5'h1E});
    check(st.done_current_pct, 5'h1E);
    rdchk(8'h0B, 8'h7F);
    host.wr(8'h0B, 8'h45);
    check({st.precharge_mv, st.precharge_current_pct}, {13'h0A8C, 5'h0A});
    check(st.done_current_pct, 5'h0A);
    // every legal regulation code, recharge code cycling with it
    for (int i = 0; i < 7; i++) begin
      host.wr(8'h0A, {2'b10, 2'(i), 3'(i), 1'b1});
      check({st.regulation_valid, st.regulation_mv}, {1'b1, 13'(4050 + 50 * i)});
      check(st.recharge_drop_mv, 10'(70 + 50 * (i % 4)));
      check({st.auto_stop_enable, st.auto_restart_enable, st.charger_on}, 3'h5);
    end
    host.wr(8'h0A, 8'h7E);
    check({st.regulation_valid, st.auto_restart_enable, st.charger_on}, 3'h2);
    check({st.auto_stop_enable, st.recharge_drop_mv}, {1'b0, 10'h0DC});
    rdchk(8'h0A, 8'h7E);
    @(posedge clk) wp <= 1'b1;
    host.wr(8'h0A, 8'h81);
    rdchk(8'h0A, 8'h7E);
    @(posedge clk) wp <= 1'b0;
    host.wr(8'h0A, 8'h81);
    rdchk(8'h0A, 8'h81);
    host.wr(8'h0D, 8'hAA);
    rdchk(8'h0D, 8'h00);
    check(hit, 1'b0);
    // supply drop and return reloads all three registers
    @(posedge clk) sup <= 1'b0;
    repeat (4) @(posedge clk);
    sup <= 1'b1;
    @(posedge clk);
    // sampled on the reload edge, so the reload must win over it
    host.wr(8'h0C, 8'h2A);
    repeat (2) @(posedge clk);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0C, 8'h00);
    check({st.regulation_mv, st.fast_limit_min}, {13'h0FD2, 10'h04B});
    print_verdict();
  end
endmodule
